// file: hdl/ccr_defs.vh
// Register indices, control field positions and reset values of the calendar/counter clock.
`ifndef CCR_DEFS_VH
`define CCR_DEFS_VH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define CCR_IDX_IRQ_ENABLE   7'h01
`define CCR_IDX_IRQ_FLAGS    7'h03
`define CCR_IDX_CONTROL      7'h41
`define CCR_IDX_COUNT0       7'h42
`define CCR_IDX_COUNT1       7'h43
`define CCR_IDX_COUNT2       7'h44
`define CCR_IDX_COUNT3       7'h45
`define CCR_IDX_DAY          7'h4c
`define CCR_IDX_MONTH        7'h4d
`define CCR_IDX_YEAR_LO      7'h4e
`define CCR_IDX_YEAR_HI      7'h4f

// ----------------------------------------------------------------------------
// Control byte fields
// ----------------------------------------------------------------------------
`define CCR_CTL_BCD          7
`define CCR_CTL_HOLD         6
`define CCR_CTL_MODE_HI      5
`define CCR_CTL_MODE_LO      4
`define CCR_CTL_EVT_HI       3
`define CCR_CTL_EVT_LO       2
`define CCR_CTL_IE           1
`define CCR_CTL_FLAG         0
`define CCR_CTL_RESET        8'h40

`define CCR_MODE_AUX         2'b00
`define CCR_MODE_TAP         2'b01
`define CCR_MODE_SUB         2'b10
`define CCR_MODE_CAL         2'b11

// ----------------------------------------------------------------------------
// Shared interrupt bytes
// ----------------------------------------------------------------------------
`define CCR_SHARED_BIT       7
`define CCR_SHARED_RESET     1'b0

`endif

// file: hdl/ccr_calendar_counter.v
// Calendar / 32-bit counter clock with an Avalon-MM register slave.
//
// Implementation choices: register access over Avalon-MM and the address map.
`default_nettype none
`include "ccr_defs.vh"

// Function
// - Control bit 7 picks hex or packed BCD calendar values.
// - Hold stops the clock; in calendar mode the prescaler stops too.
// - Mode 00 aux clock, 01 prescaler tap, 10 subsystem clock, 11 calendar.
// - Counter mode event: overflow of 8, 16, 24 or 32 bits.
// - Calendar event: minute change, hour change, midnight or noon.
// - Control bit 1 enables interrupt requests from clock events.
// - Control bit 0 is the event flag, set by the selected event.
// - In counter mode each count byte is fully readable and writable.
// - BCD minutes: tens 0-5 in bits 6-4, units in 3-0, bit 7 zero.
// - Hex hours use five low bits; upper three read zero.
// - BCD hours: tens 0-2 in bits 5-4, units in 3-0, bits 7-6 zero.
// - Weekday 0-6 in three low bits; upper five bits read zero.
// - Hex day of month counts 1 to month length in bits 4-0.
// - BCD day: tens 0-3 in bits 5-4, units in 3-0, bits 7-6 zero.
// - Hex month counts 1 to 12 in four low bits.
// - BCD century: tens 0-4 in bits 6-4, units in 3-0, bit 7 zero.
// - Shared enable bit 7 gates the shared timer flag onto the request.
// - Shared flag bit 7 clears on service or by software write.
// - With enable set, event sets both flags and requests an interrupt.
// - Entering calendar or changing format resets the calendar to day one.
// - Years divisible by four are leap years with a 29-day February.
// - In counter mode four bytes cascade into one 32-bit counter.
module ccr_calendar_counter (
  input  wire        mclk,
  input  wire        rst_n,
  input  wire [8:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  input  wire        auxClock,
  input  wire        subsystemClock,
  input  wire        prescalerTap,
  input  wire        prescalerEvent,
  input  wire        irqServiced,
  output reg         irqRequest,
  output reg         prescalerHold
);

  // --------------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------------
  function [7:0] incv;
    input [7:0] v;
    input       bcd;
    begin
      if (!bcd)
        incv = v + 8'h01;
      else if (v[3:0] == 4'h9)
        incv = {v[7:4] + 4'h1, 4'h0};
      else
        incv = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  function [7:0] enc;
    input [6:0] n;
    input       bcd;
    reg   [6:0] t;
    reg   [6:0] u;
    begin
      t = n / 7'd10;
      u = n - t * 7'd10;
      enc = bcd ? {t[3:0], u[3:0]} : {1'b0, n};
    end
  endfunction

  function [6:0] dec;
    input [7:0] v;
    input       bcd;
    begin
      dec = bcd ? ({3'h0, v[7:4]} * 7'd10 + {3'h0, v[3:0]}) : v[6:0];
    end
  endfunction

  function [6:0] monthDays;
    input [3:0] m;
    input       leap;
    begin
      case (m)
        4'd2:                      monthDays = leap ? 7'd29 : 7'd28;
        4'd4, 4'd6, 4'd9, 4'd11:   monthDays = 7'd30;
        default:                   monthDays = 7'd31;
      endcase
    end
  endfunction

  // Bits a write may set; the rest stay zero so they read as zero.
  function [7:0] wmask;
    input [6:0] idx;
    input       cal;
    input       bcd;
    begin
      if (!cal)
        wmask = 8'hff;
      else begin
        case (idx)
          `CCR_IDX_COUNT0:  wmask = bcd ? 8'h7f : 8'h3f;
          `CCR_IDX_COUNT1:  wmask = bcd ? 8'h7f : 8'h3f;
          `CCR_IDX_COUNT2:  wmask = bcd ? 8'h3f : 8'h1f;
          `CCR_IDX_COUNT3:  wmask = 8'h07;
          `CCR_IDX_DAY:     wmask = bcd ? 8'h3f : 8'h1f;
          `CCR_IDX_MONTH:   wmask = bcd ? 8'h1f : 8'h0f;
          `CCR_IDX_YEAR_HI: wmask = bcd ? 8'h7f : 8'hff;
          default:          wmask = 8'hff;
        endcase
      end
    end
  endfunction

  // --------------------------------------------------------------------------
  // Reset release and input synchronisers
  // --------------------------------------------------------------------------
  reg  [1:0] rstSync_q;
  wire       rstN = rstSync_q[1];

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      rstSync_q <= 2'b00;
    else
      rstSync_q <= {rstSync_q[0], 1'b1};
  end

  // Source clocks are sampled, so each must stay well below half of mclk.
  reg  [2:0] srcMeta_q;
  reg  [2:0] srcSync_q;
  reg  [2:0] srcLast_q;
  wire [2:0] srcRise = srcSync_q & ~srcLast_q;

  always @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      srcMeta_q <= 3'h0;
      srcSync_q <= 3'h0;
      srcLast_q <= 3'h0;
    end else begin
      srcMeta_q <= {prescalerTap, subsystemClock, auxClock};
      srcSync_q <= srcMeta_q;
      srcLast_q <= srcSync_q;
    end
  end

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  reg  [7:0] ctl_q;
  reg  [7:0] cnt0_q;
  reg  [7:0] cnt1_q;
  reg  [7:0] cnt2_q;
  reg  [7:0] cnt3_q;
  reg  [7:0] day_q;
  reg  [7:0] mon_q;
  reg  [7:0] yearLo_q;
  reg  [7:0] yearHi_q;
  reg        sharedEn_q;
  reg        sharedFlag_q;

  wire       bcd  = ctl_q[`CCR_CTL_BCD];
  wire       hold = ctl_q[`CCR_CTL_HOLD];
  wire [1:0] mode = ctl_q[`CCR_CTL_MODE_HI:`CCR_CTL_MODE_LO];
  wire [1:0] evt  = ctl_q[`CCR_CTL_EVT_HI:`CCR_CTL_EVT_LO];
  wire       ie   = ctl_q[`CCR_CTL_IE];
  wire       cal  = (mode == `CCR_MODE_CAL);

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  wire [6:0] idx     = avs_address[8:2];
  wire       accept  = (avs_read | avs_write) & ~avs_waitrequest;
  wire       wrByte  = accept & avs_write & avs_byteenable[0];
  wire [7:0] wdat    = avs_writedata[7:0];
  wire       wrCtl   = wrByte & (idx == `CCR_IDX_CONTROL);
  wire       wrCount = wrByte & ((idx >= `CCR_IDX_COUNT0 && idx <= `CCR_IDX_COUNT3) ||
                                 (idx >= `CCR_IDX_DAY && idx <= `CCR_IDX_YEAR_HI));

  // --------------------------------------------------------------------------
  // Tick selection and calendar arithmetic
  // --------------------------------------------------------------------------
  reg tickSrc;

  always @* begin
    case (mode)
      `CCR_MODE_AUX: tickSrc = srcRise[0];
      `CCR_MODE_TAP: tickSrc = srcRise[2];
      `CCR_MODE_SUB: tickSrc = srcRise[1];
      default:       tickSrc = srcRise[2];
    endcase
  end

  // A write to a counting byte stops the clock for that cycle, dropping a tick.
  wire tick = tickSrc & ~hold & ~wrCount;

  wire [6:0]  yearVal = dec(yearLo_q, bcd);
  wire        leap    = (yearVal[1:0] == 2'b00);
  wire [6:0]  monVal  = dec(mon_q, bcd);
  wire        secWrap = (cnt0_q == enc(7'd59, bcd));
  wire        minWrap = secWrap & (cnt1_q == enc(7'd59, bcd));
  wire        hrWrap  = minWrap & (cnt2_q == enc(7'd23, bcd));
  wire        noon    = minWrap & (cnt2_q == enc(7'd11, bcd));
  wire        dayWrap = hrWrap & (dec(day_q, bcd) == monthDays(monVal[3:0], leap));
  wire        monWrap = dayWrap & (monVal == 7'd12);
  wire        ylWrap  = monWrap & (yearLo_q == (bcd ? 8'h99 : 8'hff));
  wire [31:0] cntAll  = {cnt3_q, cnt2_q, cnt1_q, cnt0_q};
  wire [31:0] cntNext = cntAll + 32'h1;

  reg evtHit;

  always @* begin
    if (cal) begin
      case (evt)
        2'b00:   evtHit = secWrap;
        2'b01:   evtHit = minWrap;
        2'b10:   evtHit = hrWrap;
        default: evtHit = noon;
      endcase
    end else begin
      case (evt)
        2'b00:   evtHit = (cntAll[7:0] == 8'hff);
        2'b01:   evtHit = (cntAll[15:0] == 16'hffff);
        2'b10:   evtHit = (cntAll[23:0] == 24'hffffff);
        default: evtHit = (cntAll == 32'hffffffff);
      endcase
    end
  end

  wire event_ = tick & evtHit;

  // Control write side effects on the counting bytes.
  wire [1:0] newMode  = wdat[`CCR_CTL_MODE_HI:`CCR_CTL_MODE_LO];
  wire       newCal   = (newMode == `CCR_MODE_CAL);
  wire       calInit  = wrCtl & newCal & (~cal | (wdat[`CCR_CTL_BCD] != bcd));
  wire       cntClear = wrCtl & cal & ~newCal;
  wire [7:0] wval     = wdat & wmask(idx, cal, bcd);

  // --------------------------------------------------------------------------
  // Control and shared interrupt bits
  // --------------------------------------------------------------------------
  wire svc = irqServiced & ie;

  always @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      ctl_q        <= `CCR_CTL_RESET;
      sharedEn_q   <= `CCR_SHARED_RESET;
      sharedFlag_q <= `CCR_SHARED_RESET;
    end else begin
      if (wrCtl)
        ctl_q[7:1] <= wdat[7:1];
      // The event wins over a clear written or serviced in the same cycle.
      if (event_)
        ctl_q[`CCR_CTL_FLAG] <= 1'b1;
      else if (wrCtl)
        ctl_q[`CCR_CTL_FLAG] <= wdat[`CCR_CTL_FLAG];
      else if (svc)
        ctl_q[`CCR_CTL_FLAG] <= 1'b0;
      if (wrByte && idx == `CCR_IDX_IRQ_ENABLE)
        sharedEn_q <= wdat[`CCR_SHARED_BIT];
      if ((event_ && ie) || (prescalerEvent && !ie))
        sharedFlag_q <= 1'b1;
      else if (wrByte && idx == `CCR_IDX_IRQ_FLAGS)
        sharedFlag_q <= wdat[`CCR_SHARED_BIT];
      else if (irqServiced)
        sharedFlag_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Counting bytes: kept across reset, so they carry no reset branch
  // --------------------------------------------------------------------------
  always @(posedge mclk) begin
    if (calInit) begin
      cnt0_q   <= 8'h00;
      cnt1_q   <= 8'h00;
      cnt2_q   <= 8'h00;
      cnt3_q   <= 8'h00;
      day_q    <= 8'h01;
      mon_q    <= 8'h01;
      yearLo_q <= 8'h00;
      yearHi_q <= 8'h00;
    end else if (cntClear) begin
      cnt0_q <= 8'h00;
      cnt1_q <= 8'h00;
      cnt2_q <= 8'h00;
      cnt3_q <= 8'h00;
    end else if (wrCount) begin
      case (idx)
        `CCR_IDX_COUNT0:  cnt0_q <= wval;
        `CCR_IDX_COUNT1:  cnt1_q <= wval;
        `CCR_IDX_COUNT2:  cnt2_q <= wval;
        `CCR_IDX_COUNT3:  cnt3_q <= wval;
        `CCR_IDX_DAY:     day_q <= wval;
        `CCR_IDX_MONTH:   mon_q <= wval;
        `CCR_IDX_YEAR_LO: yearLo_q <= wval;
        default:          yearHi_q <= wval;
      endcase
    end else if (tick && !cal) begin
      cnt0_q <= cntNext[7:0];
      cnt1_q <= cntNext[15:8];
      cnt2_q <= cntNext[23:16];
      cnt3_q <= cntNext[31:24];
    end else if (tick) begin
      cnt0_q <= secWrap ? 8'h00 : incv(cnt0_q, bcd);
      if (secWrap)
        cnt1_q <= minWrap ? 8'h00 : incv(cnt1_q, bcd);
      if (minWrap)
        cnt2_q <= hrWrap ? 8'h00 : incv(cnt2_q, bcd);
      if (hrWrap) begin
        cnt3_q <= (cnt3_q == 8'h06) ? 8'h00 : cnt3_q + 8'h01;
        day_q  <= dayWrap ? 8'h01 : incv(day_q, bcd);
      end
      if (dayWrap)
        mon_q <= monWrap ? 8'h01 : incv(mon_q, bcd);
      if (monWrap)
        yearLo_q <= ylWrap ? 8'h00 : incv(yearLo_q, bcd);
      if (ylWrap)
        yearHi_q <= incv(yearHi_q, bcd);
    end
  end

  // --------------------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------------------
  reg [7:0] rdByte;

  always @* begin
    case (idx)
      `CCR_IDX_CONTROL:    rdByte = ctl_q;
      `CCR_IDX_COUNT0:     rdByte = cnt0_q;
      `CCR_IDX_COUNT1:     rdByte = cnt1_q;
      `CCR_IDX_COUNT2:     rdByte = cnt2_q;
      `CCR_IDX_COUNT3:     rdByte = cnt3_q;
      `CCR_IDX_DAY:        rdByte = day_q;
      `CCR_IDX_MONTH:      rdByte = mon_q;
      `CCR_IDX_YEAR_LO:    rdByte = yearLo_q;
      `CCR_IDX_YEAR_HI:    rdByte = yearHi_q;
      `CCR_IDX_IRQ_ENABLE: rdByte = {sharedEn_q, 7'h00};
      `CCR_IDX_IRQ_FLAGS:  rdByte = {sharedFlag_q, 7'h00};
      default:             rdByte = 8'h00;
    endcase
  end

  // --------------------------------------------------------------------------
  // Bus handshake and outputs
  // --------------------------------------------------------------------------
  // Every request waits exactly one cycle; read data is latched with the drop.
  always @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
      irqRequest      <= 1'b0;
      prescalerHold   <= 1'b0;
    end else begin
      if ((avs_read || avs_write) && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        avs_readdata    <= avs_read ? {24'h0, rdByte} : 32'h0;
      end else begin
        avs_waitrequest <= 1'b1;
      end
      irqRequest    <= sharedFlag_q & sharedEn_q;
      prescalerHold <= hold & cal;
    end
  end

endmodule
`default_nettype wire

// file: tb/ccr_src_model.sv
// Counting-clock sources standing beside the clock block.
`default_nettype none
module ccr_src_model (
  input  wire logic       mclk,
  input  wire logic [2:0] pulseGo,
  output wire logic       auxClock,
  output wire logic       prescalerTap,
  output wire logic       subsystemClock
);
  timeunit 1ns;
  timeprecision 1ps;
  // Each source gives one slow pulse per request and then stands still low.
  logic [3:0] left_q [0:2] = '{4'h0, 4'h0, 4'h0};
  always @(posedge mclk) begin
    for (int i = 0; i < 3; i++) begin
      if (pulseGo[i])
        left_q[i] <= 4'h8;
      else if (left_q[i] != 4'h0)
        left_q[i] <= left_q[i] - 4'h1;
    end
  end
  assign auxClock       = left_q[0] > 4'h4;
  assign prescalerTap   = left_q[1] > 4'h4;
  assign subsystemClock = left_q[2] > 4'h4;
endmodule
`default_nettype wire

// file: tb/ccr_calendar_counter_properties.sv
// Port-level checks of the calendar/counter clock.
`default_nettype none
module ccr_props (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic [8:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        prescalerEvent,
  input wire logic        irqServiced,
  input wire logic        irqRequest,
  input wire logic        prescalerHold
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // An access is taken at the edge where waitrequest is seen low.
  sequence s_wr(idx);
    avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address[8:2] == idx;
  endsequence
  sequence s_rd(idx);
    avs_read && !avs_waitrequest && avs_address[8:2] == idx;
  endsequence
  a_wait_answer: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
    else $error("request not answered in one cycle");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_wait_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("answer without request");
  a_read_upper: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  a_unmapped_zero: assert property (s_rd(7'h10) |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_shared_bits: assert property ((s_rd(7'h01) or s_rd(7'h03)) |-> avs_readdata[6:0] == 7'h0)
    else $error("foreign shared bits not zero");
  a_enable_gate: assert property (s_wr(7'h01) ##0 !avs_writedata[7] |-> ##2 !irqRequest)
    else $error("request not gated by enable");
  a_service_clear: assert property (irqServiced && !prescalerEvent |-> ##2 !irqRequest)
    else $error("service left request up");
  a_hold_follows: assert property (s_wr(7'h41) |-> ##2 prescalerHold ==
    ($past(avs_writedata[6], 2) && $past(avs_writedata[5:4], 2) == 2'b11))
    else $error("prescaler hold wrong");
endmodule
bind ccr_calendar_counter ccr_props chk_u (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .prescalerEvent(prescalerEvent), .irqServiced(irqServiced), .irqRequest(irqRequest),
  .prescalerHold(prescalerHold));
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the calendar/counter clock.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic [8:0]  avsAddress = 9'h0;
  logic        avsRead = 1'b0;
  logic        avsWrite = 1'b0;
  logic [31:0] avsWritedata = 32'h0;
  logic [3:0]  avsByteEnable = 4'h1;
  logic [31:0] avsReaddata;
  logic        avsWaitrequest;
  logic [2:0]  pulseGo = 3'h0;
  logic        prescalerEvent = 1'b0;
  logic        irqServiced = 1'b0;
  logic        auxClock, prescalerTap, subsystemClock, irqRequest, prescalerHold;
  logic [7:0]  rdv, ctl;
  int          n_fail = 0;
  int          n_checks = 0;
  ccr_calendar_counter dut_u (.mclk(mclk), .rst_n(rst_n), .avs_address(avsAddress), .avs_read(avsRead),
    .avs_write(avsWrite), .avs_writedata(avsWritedata), .avs_byteenable(avsByteEnable),
    .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest), .auxClock(auxClock),
    .subsystemClock(subsystemClock), .prescalerTap(prescalerTap), .prescalerEvent(prescalerEvent),
    .irqServiced(irqServiced), .irqRequest(irqRequest), .prescalerHold(prescalerHold));
  ccr_src_model src_u (.mclk(mclk), .pulseGo(pulseGo), .auxClock(auxClock), .prescalerTap(prescalerTap),
    .subsystemClock(subsystemClock));
  initial begin
    forever #2 mclk = ~mclk;
  end
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // The request is held until the edge that sees waitrequest low.
  task automatic bus(input logic wr, input logic [6:0] idx, input logic [7:0] wd);
    int i;
    @(posedge mclk);
    avsAddress   <= {idx, 2'b00};
    avsRead      <= !wr;
    avsWrite     <= wr;
    avsWritedata <= {24'h0, wd};
    for (i = 0; i < 16; i++) begin
      @(posedge mclk);
      if (avsWaitrequest === 1'b0)
        break;
    end
    if (i == 16) begin
      n_fail++;
      conclude();
    end
    rdv = avsReaddata[7:0];
    avsRead  <= 1'b0;
    avsWrite <= 1'b0;
  endtask
  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask
  task automatic rd(input string nm, input logic [6:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h0);
    chk(nm, exp, rdv);
  endtask
  task automatic tick(input int s);
    @(posedge mclk);
    pulseGo[s] <= 1'b1;
    @(posedge mclk);
    pulseGo <= 3'h0;
    repeat (14) @(posedge mclk);
  endtask
  function automatic logic [6:0] ci(input int k);
    return 7'(66 + k + (k > 3 ? 6 : 0));
  endfunction
  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    rd("control", 7'h41, 8'h40);
    rd("enable", 7'h01, 8'h00);
    rd("flags", 7'h03, 8'h00);
    wr(7'h10, 8'h5a);
    rd("unmapped", 7'h10, 8'h00);
    for (int e = 0; e < 4; e++) begin
      ctl = {2'b00, 2'(e % 3), 2'(e), 2'b00};
      wr(7'h41, ctl);
      for (int k = 0; k < 4; k++)
        wr(ci(k), (k < e) ? 8'hff : (k == e) ? 8'hfe : 8'h00);
      tick(e % 3);
      rd("control", 7'h41, ctl);
      rd("byte", ci(e), 8'hff);
      for (int k = 0; k < e; k++) begin
        rd("carry", ci(k), 8'h00);
        wr(ci(k), 8'hff);
      end
      tick(e % 3);
      rd("event flag", 7'h41, ctl | 8'h01);
      for (int k = 0; k < 4; k++)
        rd("cascade", ci(k), (k == e + 1) ? 8'h01 : 8'h00);
    end
    wr(7'h41, 8'h40);
    wr(7'h42, 8'h10);
    tick(0);
    rd("held", 7'h42, 8'h10);
    avsByteEnable <= 4'h0;
    wr(7'h42, 8'h77);
    avsByteEnable <= 4'h1;
    rd("lane off", 7'h42, 8'h10);
    bus(1'b0, 7'h01, 8'h0);
    wr(7'h01, rdv | 8'h80);
    wr(7'h41, 8'h02);
    wr(7'h42, 8'hff);
    tick(0);
    chk("irq", 8'h01, {7'h0, irqRequest});
    rd("flags", 7'h03, 8'h80);
    rd("control", 7'h41, 8'h03);
    irqServiced <= 1'b1;
    @(posedge mclk);
    irqServiced <= 1'b0;
    repeat (3) @(posedge mclk);
    chk("irq", 8'h00, {7'h0, irqRequest});
    rd("control", 7'h41, 8'h02);
    wr(7'h41, 8'h00);
    wr(7'h42, 8'hff);
    tick(0);
    rd("control", 7'h41, 8'h01);
    rd("flags", 7'h03, 8'h00);
    prescalerEvent <= 1'b1;
    @(posedge mclk);
    prescalerEvent <= 1'b0;
    repeat (3) @(posedge mclk);
    chk("irq", 8'h01, {7'h0, irqRequest});
    // Software clears only its own bit and leaves the other modules' bits as read.
    bus(1'b0, 7'h01, 8'h0);
    wr(7'h01, rdv & 8'h7f);
    repeat (2) @(posedge mclk);
    chk("irq", 8'h00, {7'h0, irqRequest});
    bus(1'b0, 7'h03, 8'h0);
    wr(7'h03, rdv & 8'h7f);
    rd("flags", 7'h03, 8'h00);
    wr(7'h41, 8'h70);
    repeat (2) @(posedge mclk);
    chk("hold", 8'h01, {7'h0, prescalerHold});
    for (int k = 0; k < 8; k++)
      rd("init", ci(k), (k == 4 || k == 5) ? 8'h01 : 8'h00);
    wr(7'h42, 8'h3b);
    wr(7'h43, 8'h3b);
    wr(7'h44, 8'h0b);
    wr(7'h41, 8'h3c);
    tick(1);
    rd("seconds", 7'h42, 8'h00);
    rd("hours", 7'h44, 8'h0c);
    rd("noon", 7'h41, 8'h3d);
    wr(7'h41, 8'hf0);
    rd("format", 7'h44, 8'h00);
    for (int v = 0; v < 4; v++) begin
      ctl = 8'hb0 | 8'(v << 2);
      wr(7'h41, ctl);
      for (int k = 0; k < 8; k++)
        wr(ci(k), 8'(64'h5959230628020420 >> (56 - 8 * k)));
      tick(1);
      for (int k = 0; k < 8; k++)
        rd("bcd", ci(k), 8'(64'h0000000029020420 >> (56 - 8 * k)));
      rd("bcd event", 7'h41, ctl | 8'(v != 3));
    end
    // A second reset in mid-run: control and shared bits return, counting bytes survive.
    rst_n <= 1'b0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    chk("hold", 8'h00, {7'h0, prescalerHold});
    rd("control", 7'h41, 8'h40);
    rd("enable", 7'h01, 8'h00);
    rd("kept", 7'h4c, 8'h29);
    rd("kept", 7'h4f, 8'h20);
    conclude();
  end
endmodule
`default_nettype wire
